// file: rtl/hipc_consts.svh
`ifndef HIPC_CONSTS_SVH
`define HIPC_CONSTS_SVH
// Register offsets
`define OFS_PAGE_CONTROL 9'h100
`define OFS_IF_SETUP 9'h105
`define OFS_IF_SELECT 9'h106
// Writable bit masks; reserved bits stay zero
`define MASK_PAGE_CONTROL 8'hc7
`define MASK_IF_SETUP 8'hff
`define MASK_IF_SELECT 8'hf0
// page_control fields
`define BIT_AUTO_PAGE 7
`define BIT_WRITE_MODE 6
`define PAGE_MSB 2
`define PAGE_TWO_WIRE_BIT 1
`define PAGE_FOUR_WIRE_MAX 3'h2
// serial_interface_setup fields
`define NIB_MSB 7
`define NIB_LSB 4
`define BIT_DIR_POL 3
`define BIT_CPHA 2
`define BIT_CPOL 1
`define BIT_CS_POL 0
// serial_interface_select fields
`define BIT_IF_TYPE 7
`define BIT_PERM_HS 6
`define BIT_FAST_PLUS 5
`define BIT_SUPPLY 4
// Reset values
`define RST_PAGE_CONTROL 8'h00
`define RST_IF_SETUP 8'h00
`define RST_IF_SELECT 8'h80
// Hardware default two-wire address nibble
`define DEFAULT_NIBBLE 4'hd
`define UNPROGRAMMED_NIBBLE 4'h0
// Two-wire high-speed master code, top five bits
`define HS_CODE_TOP 5'h01
`endif

// file: rtl/hipc_pkg.sv
package hipc_pkg;
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_REG = 3'b010,
    TW_WDATA = 3'b011,
    TW_RDATA = 3'b100
  } tw_state_t;
endpackage : hipc_pkg

// file: rtl/host_interface_page_config.sv
`timescale 1ns/1ps
`include "hipc_consts.svh"

module host_interface_page_config #(
  parameter logic [7:0] PAGE_RESET = `RST_PAGE_CONTROL,
  parameter logic [7:0] SETUP_RESET = `RST_IF_SETUP,
  parameter logic [7:0] SELECT_RESET = `RST_IF_SELECT,
  parameter logic [3:0] DEFAULT_NIBBLE = `DEFAULT_NIBBLE
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Two-wire link, open drain data
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Four-wire link on the borrowed pins
  input wire logic CHIP_SELECT,
  input wire logic FOUR_WIRE_CLOCK,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  // Configuration seen by the rest of the device
  output logic [2:0] PAGE_SELECT,
  output logic REPEATED_WRITE,
  output logic FOUR_WIRE_PINS,
  output logic HIGH_SPEED,
  output logic FAST_PLUS,
  output logic LINK_SUPPLY_IO
);

  // Registers
  logic [7:0] page_control;
  logic [7:0] serial_interface_setup;
  logic [7:0] serial_interface_select;

  // Pin synchronisers
  logic [1:0] scl_q, sda_q, cs_q, sck_q, mosi_q;
  logic scl_d, sda_d, sck_d;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      cs_q <= 2'h0;
      sck_q <= 2'h0;
      mosi_q <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      scl_q <= {scl_q[0], SCL};
      sda_q <= {sda_q[0], SDA_IN};
      cs_q <= {cs_q[0], CHIP_SELECT};
      sck_q <= {sck_q[0], FOUR_WIRE_CLOCK};
      mosi_q <= {mosi_q[0], MOSI};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
      sck_d <= sck_q[1];
    end
  end

  logic two_wire;
  logic [3:0] eff_nibble;
  logic cpol, cpha, cs_act;
  assign two_wire = serial_interface_select[`BIT_IF_TYPE];
  assign eff_nibble = (serial_interface_setup[`NIB_MSB:`NIB_LSB] == `UNPROGRAMMED_NIBBLE) ?
    DEFAULT_NIBBLE : serial_interface_setup[`NIB_MSB:`NIB_LSB];
  assign cpol = serial_interface_setup[`BIT_CPOL];
  assign cpha = serial_interface_setup[`BIT_CPHA];
  assign cs_act = !two_wire && (cs_q[1] == serial_interface_setup[`BIT_CS_POL]);

  // Shared register port
  logic reg_we;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata;

  function automatic logic [7:0] read_reg(input logic [8:0] a, input logic [7:0] pc,
                                          input logic [7:0] su, input logic [7:0] se);
    case (a)
      `OFS_PAGE_CONTROL: read_reg = pc & `MASK_PAGE_CONTROL;
      `OFS_IF_SETUP: read_reg = su & `MASK_IF_SETUP;
      `OFS_IF_SELECT: read_reg = se & `MASK_IF_SELECT;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Two-wire slave
  hipc_pkg::tw_state_t tw_state;
  logic [3:0] tw_cnt;
  logic tw_ack, tw_pair, tw_nack, hs_entered;
  logic [7:0] tw_sh, tw_out, tw_reg;
  logic tw_start, tw_stop, tw_rise, tw_fall, tw_we;
  logic [8:0] tw_full;
  assign tw_start = two_wire && scl_q[1] && scl_d && sda_d && !sda_q[1];
  assign tw_stop = two_wire && scl_q[1] && scl_d && !sda_d && sda_q[1];
  assign tw_rise = two_wire && scl_q[1] && !scl_d;
  assign tw_fall = two_wire && !scl_q[1] && scl_d;
  // Pair bit or page bit 1 opens the upper bank
  assign tw_full = {page_control[`PAGE_TWO_WIRE_BIT] | tw_pair, tw_reg};
  // Read word held apart so its top bit can be picked without indexing a call
  logic [7:0] tw_rd;
  assign tw_rd = read_reg(tw_full, page_control, serial_interface_setup,
                          serial_interface_select);
  assign tw_we = tw_fall && !tw_ack && tw_cnt == 4'h8 && tw_state == hipc_pkg::TW_WDATA;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tw_state <= hipc_pkg::TW_IDLE;
      tw_cnt <= 4'h0;
      tw_ack <= 1'b0;
      tw_pair <= 1'b0;
      tw_nack <= 1'b0;
      tw_sh <= 8'h00;
      tw_out <= 8'h00;
      tw_reg <= 8'h00;
      hs_entered <= 1'b0;
      SDA_OE <= 1'b0;
    end else if (tw_start) begin
      tw_state <= hipc_pkg::TW_ADDR;
      tw_cnt <= 4'h0;
      tw_ack <= 1'b0;
      SDA_OE <= 1'b0;
    end else if (tw_stop || !two_wire) begin
      tw_state <= hipc_pkg::TW_IDLE;
      tw_ack <= 1'b0;
      hs_entered <= 1'b0;
      SDA_OE <= 1'b0;
    end else if (tw_rise && tw_state != hipc_pkg::TW_IDLE) begin
      if (!tw_ack) begin
        tw_sh <= {tw_sh[6:0], sda_q[1]};
        tw_cnt <= tw_cnt + 4'h1;
      end else begin
        tw_nack <= sda_q[1];
      end
    end else if (tw_fall && tw_state != hipc_pkg::TW_IDLE) begin
      if (!tw_ack && tw_cnt == 4'h8) begin
        tw_ack <= 1'b1;
        case (tw_state)
          hipc_pkg::TW_ADDR: begin
            if (tw_sh[7:3] == `HS_CODE_TOP) begin
              // Master code is never acknowledged
              hs_entered <= 1'b1;
              tw_state <= hipc_pkg::TW_IDLE;
            end else if (tw_sh[7:4] == eff_nibble && tw_sh[3:2] == 2'h0) begin
              tw_pair <= tw_sh[1];
              tw_nack <= 1'b0;
              SDA_OE <= 1'b1;
              tw_state <= tw_sh[0] ? hipc_pkg::TW_RDATA : hipc_pkg::TW_REG;
            end else begin
              tw_state <= hipc_pkg::TW_IDLE;
            end
          end
          hipc_pkg::TW_REG: begin
            tw_reg <= tw_sh;
            SDA_OE <= 1'b1;
            tw_state <= hipc_pkg::TW_WDATA;
          end
          hipc_pkg::TW_WDATA: begin
            SDA_OE <= 1'b1;
            if (page_control[`BIT_WRITE_MODE]) begin
              tw_state <= hipc_pkg::TW_REG;
            end else begin
              tw_reg <= tw_reg + 8'h01;
            end
          end
          hipc_pkg::TW_RDATA: SDA_OE <= 1'b0;
          default: tw_state <= hipc_pkg::TW_IDLE;
        endcase
      end else if (tw_ack) begin
        tw_ack <= 1'b0;
        tw_cnt <= 4'h0;
        if (tw_state == hipc_pkg::TW_RDATA) begin
          if (tw_nack) begin
            // Host ended the read; wait for stop
            tw_state <= hipc_pkg::TW_IDLE;
            SDA_OE <= 1'b0;
          end else begin
            tw_out <= tw_rd << 1;
            SDA_OE <= !tw_rd[7];
            tw_reg <= tw_reg + 8'h01;
          end
        end else begin
          SDA_OE <= 1'b0;
        end
      end else if (tw_state == hipc_pkg::TW_RDATA) begin
        SDA_OE <= !tw_out[7];
        tw_out <= tw_out << 1;
      end
    end
  end

  // Four-wire slave
  logic [2:0] sp_cnt;
  logic [7:0] sp_sh, sp_out;
  logic [6:0] sp_addr;
  logic sp_first, sp_rd, sp_sample, sp_shift, sp_lead, sp_trail, sp_we, sp_valid;
  logic [7:0] sp_byte;
  logic [8:0] sp_full;
  assign sp_lead = cs_act && (cpol ? (sck_d && !sck_q[1]) : (!sck_d && sck_q[1]));
  assign sp_trail = cs_act && (cpol ? (!sck_d && sck_q[1]) : (sck_d && !sck_q[1]));
  assign sp_sample = cpha ? sp_trail : sp_lead;
  assign sp_shift = cpha ? sp_lead : sp_trail;
  assign sp_byte = {sp_sh[6:0], mosi_q[1]};
  assign sp_valid = page_control[`PAGE_MSB:0] <= `PAGE_FOUR_WIRE_MAX;
  assign sp_full = {page_control[1:0], sp_addr};
  assign sp_we = sp_sample && sp_cnt == 3'h7 && !sp_first && !sp_rd && sp_valid;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sp_cnt <= 3'h0;
      sp_sh <= 8'h00;
      sp_out <= 8'h00;
      sp_addr <= 7'h00;
      sp_first <= 1'b1;
      sp_rd <= 1'b0;
      MISO <= 1'b0;
      MISO_OE <= 1'b0;
    end else if (!cs_act) begin
      sp_cnt <= 3'h0;
      sp_first <= 1'b1;
      sp_rd <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= 1'b1;
      if (sp_sample) begin
        sp_sh <= sp_byte;
        sp_cnt <= sp_cnt + 3'h1;
        if (sp_cnt == 3'h7) begin
          if (sp_first) begin
            sp_first <= 1'b0;
            sp_rd <= (mosi_q[1] == serial_interface_setup[`BIT_DIR_POL]);
            if (mosi_q[1] == serial_interface_setup[`BIT_DIR_POL]) begin
              sp_out <= sp_valid ? read_reg({page_control[1:0], sp_sh[6:0]}, page_control,
                serial_interface_setup, serial_interface_select) : 8'h00;
              sp_addr <= sp_sh[6:0] + 7'h01;
            end else begin
              sp_addr <= sp_sh[6:0];
            end
          end else begin
            if (sp_rd) begin
              sp_out <= sp_valid ? read_reg(sp_full, page_control, serial_interface_setup,
                                            serial_interface_select) : 8'h00;
            end
            sp_addr <= sp_addr + 7'h01;
          end
        end
      end else if (sp_shift && sp_rd) begin
        MISO <= sp_out[7];
        sp_out <= sp_out << 1;
      end
    end
  end

  // Transaction end for page return
  logic end_txn, cs_was;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_was <= 1'b0;
    end else begin
      cs_was <= cs_act;
    end
  end
  assign end_txn = tw_stop || (cs_was && !cs_act);

  assign reg_we = tw_we || sp_we;
  assign reg_addr = tw_we ? tw_full : sp_full;
  assign reg_wdata = tw_we ? tw_sh : sp_byte;

  // Register file; page return is applied after any write in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      page_control <= PAGE_RESET & `MASK_PAGE_CONTROL;
      serial_interface_setup <= SETUP_RESET;
      serial_interface_select <= SELECT_RESET & `MASK_IF_SELECT;
    end else begin
      if (reg_we) begin
        case (reg_addr)
          `OFS_PAGE_CONTROL: page_control <= reg_wdata & `MASK_PAGE_CONTROL;
          `OFS_IF_SETUP: serial_interface_setup <= reg_wdata & `MASK_IF_SETUP;
          `OFS_IF_SELECT: serial_interface_select <= reg_wdata & `MASK_IF_SELECT;
          default: ;
        endcase
      end
      if (end_txn && page_control[`BIT_AUTO_PAGE]) begin
        page_control[`PAGE_MSB:0] <= 3'h0;
      end
    end
  end

  // Configuration outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SDA_OUT <= 1'b0;
      PAGE_SELECT <= 3'h0;
      REPEATED_WRITE <= 1'b0;
      FOUR_WIRE_PINS <= 1'b0;
      HIGH_SPEED <= 1'b0;
      FAST_PLUS <= 1'b0;
      LINK_SUPPLY_IO <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      PAGE_SELECT <= page_control[`PAGE_MSB:0];
      REPEATED_WRITE <= page_control[`BIT_WRITE_MODE];
      FOUR_WIRE_PINS <= !two_wire;
      HIGH_SPEED <= two_wire && (serial_interface_select[`BIT_PERM_HS] || hs_entered);
      FAST_PLUS <= two_wire && serial_interface_select[`BIT_FAST_PLUS];
      // Four-wire pins sit on the IO rail whatever the select bit says
      LINK_SUPPLY_IO <= !two_wire || serial_interface_select[`BIT_SUPPLY];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  page_return_a: assert property (end_txn && page_control[`BIT_AUTO_PAGE] && !RST |=> page_control[2:0] == 3'h0) else $error("page not returned");
  repeat_mode_a: assert property (tw_we && page_control[`BIT_WRITE_MODE] |=> tw_state == hipc_pkg::TW_REG) else $error("repeated write not back to address");
  page_write_a: assert property (tw_we && !page_control[`BIT_WRITE_MODE] && !tw_stop |=> tw_reg == $past(tw_reg) + 8'h01) else $error("page write did not advance");
  two_wire_bank_a: assert property (tw_we |-> reg_addr[8] == (page_control[1] | tw_pair) && reg_addr[7:0] == tw_reg) else $error("two-wire bank wrong");
  four_wire_window_a: assert property (sp_we |-> page_control[2:0] <= 3'h2 && reg_addr[8:7] == page_control[1:0]) else $error("four-wire window wrong");
  addr_match_a: assert property (tw_fall && !tw_ack && tw_cnt == 4'h8 && tw_state == hipc_pkg::TW_ADDR && tw_sh[7:4] != eff_nibble && !tw_start && !tw_stop |=> !SDA_OE) else $error("foreign address acknowledged");
  pair_bit_a: assert property (tw_fall && !tw_ack && tw_cnt == 4'h8 && tw_state == hipc_pkg::TW_ADDR && tw_sh[7:4] == eff_nibble && tw_sh[3:2] == 2'h0 && !tw_start && !tw_stop |=> SDA_OE && tw_pair == $past(tw_sh[1])) else $error("pair not acknowledged");
  default_nibble_a: assert property (serial_interface_setup[7:4] == 4'h0 |-> eff_nibble == DEFAULT_NIBBLE) else $error("unprogrammed nibble not defaulted");
  direction_a: assert property (sp_sample && sp_first && sp_cnt == 3'h7 |=> sp_rd == ($past(mosi_q[1]) == serial_interface_setup[3])) else $error("direction misread");
  sample_edge_a: assert property (sp_sample |-> (sck_q[1] != cpol) == !cpha) else $error("wrong sampling edge");
  select_idle_a: assert property (!cs_act |=> !MISO_OE) else $error("MISO driven while deselected");
  pin_takeover_a: assert property (##1 FOUR_WIRE_PINS == !$past(serial_interface_select[7])) else $error("pin takeover lags");
  speed_flags_a: assert property (two_wire && serial_interface_select[6] |=> HIGH_SPEED) else $error("high speed not held");
  fast_plus_a: assert property (two_wire && serial_interface_select[5] |=> FAST_PLUS) else $error("fast plus not set");
  supply_a: assert property (!two_wire |=> LINK_SUPPLY_IO) else $error("four-wire not on IO rail");
  reserved_zero_a: assert property (page_control[5:3] == 3'h0 && serial_interface_select[3:0] == 4'h0) else $error("reserved bit set");

  tw_write_c: cover property (tw_we ##[1:400] tw_stop);
  tw_read_c: cover property (tw_state == hipc_pkg::TW_RDATA && tw_ack ##[1:400] tw_stop);
  sp_write_c: cover property (sp_we ##[1:100] !cs_act);
  auto_page_a_c: cover property (end_txn && page_control[`BIT_AUTO_PAGE] && page_control[2:0] != 3'h0);

endmodule : host_interface_page_config

// file: test/hipc_host.sv
`timescale 1ns/1ps
module hipc_host (
  // Clock
  input wire logic clk,
  // Two-wire pins
  output logic scl,
  output logic sda_in,
  input wire logic sda_oe,
  // Four-wire pins
  output logic cs,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  logic sda;
  logic cpol;
  logic cpha;
  logic cs_act;
  // Open drain with pull-up: either party pulling low wins
  assign sda_in = sda & !sda_oe;
  initial begin
    sda = 1'b1;
    scl = 1'b1;
    cpol = 1'b0;
    cpha = 1'b0;
    cs_act = 1'b0;
    cs = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // Data only moves while the clock is low, so no false start or stop
  task automatic tw_bit(input logic b, output logic r);
    sda <= b;
    w(4);
    scl <= 1'b1;
    w(8);
    r = sda_in;
    scl <= 1'b0;
    w(4);
  endtask : tw_bit
  task automatic tw_start;
    sda <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(8);
    sda <= 1'b0;
    w(8);
    scl <= 1'b0;
    w(4);
  endtask : tw_start
  task automatic tw_stop;
    sda <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(8);
    sda <= 1'b1;
    w(8);
  endtask : tw_stop
  // Reads always end with a release, which the device sees as the last byte
  task automatic tw_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) tw_bit(d[i], q[i]);
    tw_bit(1'b1, ack);
    ack = !ack;
  endtask : tw_byte
  task automatic fw_mode(input logic ph, input logic pol, input logic act);
    cpha <= ph;
    cpol <= pol;
    cs_act <= act;
    cs <= !act;
    sck <= pol;
    w(2);
  endtask : fw_mode
  task automatic fw(input logic [15:0] sh, output logic [7:0] q);
    cs <= cs_act;
    w(8);
    for (int i = 15; i >= 0; i--) begin
      if (!cpha) begin
        mosi <= sh[i];
      end
      w(8);
      sck <= !cpol;
      if (cpha) begin
        mosi <= sh[i];
      end else begin
        q = {q[6:0], miso};
      end
      w(8);
      sck <= cpol;
      if (cpha) begin
        q = {q[6:0], miso};
      end
    end
    w(8);
    cs <= !cs_act;
    mosi <= !mosi;
    w(8);
  endtask : fw
endmodule : hipc_host

// file: test/host_interface_page_config_tb.sv
`timescale 1ns/1ps
module host_interface_page_config_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_in, sda_out, sda_oe, cs, sck, mosi, miso, miso_oe;
  logic [2:0] page_sel;
  logic rep_wr, fw_pins, hs, fp, sup_io;
  int num_errors = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  host_interface_page_config dut (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CHIP_SELECT(cs), .FOUR_WIRE_CLOCK(sck), .MOSI(mosi),
    .MISO(miso), .MISO_OE(miso_oe), .PAGE_SELECT(page_sel), .REPEATED_WRITE(rep_wr),
    .FOUR_WIRE_PINS(fw_pins), .HIGH_SPEED(hs), .FAST_PLUS(fp), .LINK_SUPPLY_IO(sup_io));
  // Open drain pulls only when enabled with a low value; a released MISO shows the inverse
  hipc_host host (.clk(clk), .scl(scl), .sda_in(sda_in), .sda_oe(sda_oe && !sda_out),
    .cs(cs), .sck(sck), .mosi(mosi), .miso(miso_oe ? miso : !miso));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d, input logic ok);
    logic [7:0] q;
    logic ack;
    host.tw_start();
    host.tw_byte(a, q, ack);
    check(ack, ok);
    if (ok) begin
      host.tw_byte(r, q, ack);
      host.tw_byte(d, q, ack);
    end
    host.tw_stop();
  endtask : wr
  // Pointer set by a write, then a repeated start turns the link round
  task automatic rd(input logic [7:0] a, input logic [7:0] r, output logic [7:0] d);
    logic ack;
    host.tw_start();
    host.tw_byte(a, d, ack);
    host.tw_byte(r, d, ack);
    host.tw_start();
    host.tw_byte({a[7:1], 1'b1}, d, ack);
    check(ack, 1'b1);
    host.tw_byte(8'hff, d, ack);
    host.tw_stop();
  endtask : rd
  task automatic s_reset;
    logic [7:0] d;
    check({page_sel, rep_wr, fw_pins, hs, fp, sup_io}, 8'h00);
    check({sda_oe, sda_out, miso_oe}, 3'h0);
    rd(8'hd2, 8'h05, d);
    check(d, 8'h00);
  endtask : s_reset
  task automatic s_refuse;
    wr(8'ha2, 8'h06, 8'h00, 1'b0);
    wr(8'hd6, 8'h06, 8'h00, 1'b0);
    check(fw_pins, 1'b0);
  endtask : s_refuse
  task automatic s_modes;
    logic [7:0] v[4] = '{8'hff, 8'h90, 8'hc0, 8'ha0};
    logic [7:0] d;
    foreach (v[i]) begin
      wr(8'hd2, 8'h06, v[i], 1'b1);
      check(hs, v[i][6]);
      check(fp, v[i][5]);
      check(sup_io, v[i][4]);
      check(fw_pins, 1'b0);
      rd(8'hd2, 8'h06, d);
      check(d, v[i] & 8'hf0);
    end
  endtask : s_modes
  task automatic s_page;
    logic [7:0] d;
    wr(8'hd2, 8'h00, 8'h79, 1'b1);
    check(page_sel, 3'h1);
    check(rep_wr, 1'b1);
    rd(8'hd2, 8'h00, d);
    check(d, 8'h41);
    wr(8'hd2, 8'h00, 8'h03, 1'b1);
    rd(8'hd0, 8'h00, d);
    check(d, 8'h03);
    wr(8'hd2, 8'h00, 8'h83, 1'b1);
    check(page_sel, 3'h0);
    rd(8'hd2, 8'h00, d);
    check(d, 8'h80);
    wr(8'hd2, 8'h00, 8'h02, 1'b1);
    check(page_sel, 3'h2);
  endtask : s_page
  // Multi-byte writes: page mode advances the pointer, repeated mode takes address-data pairs
  task automatic s_burst;
    logic [7:0] q;
    logic ack;
    host.tw_start();
    host.tw_byte(8'hd2, q, ack);
    host.tw_byte(8'h05, q, ack);
    host.tw_byte(8'h00, q, ack);
    host.tw_byte(8'hb0, q, ack);
    host.tw_stop();
    check(fp, 1'b1);
    check(sup_io, 1'b1);
    wr(8'hd2, 8'h00, 8'h42, 1'b1);
    host.tw_start();
    host.tw_byte(8'hd2, q, ack);
    host.tw_byte(8'h06, q, ack);
    host.tw_byte(8'h90, q, ack);
    host.tw_byte(8'h05, q, ack);
    host.tw_byte(8'h00, q, ack);
    host.tw_stop();
    check(fp, 1'b0);
    rd(8'hd2, 8'h06, q);
    check(q, 8'h90);
    wr(8'hd2, 8'h00, 8'h02, 1'b1);
    check(rep_wr, 1'b0);
  endtask : s_burst
  // High-speed master code is never acknowledged and holds high speed until stop
  task automatic s_master;
    logic [7:0] q;
    logic ack;
    host.tw_start();
    host.tw_byte(8'h08, q, ack);
    check(ack, 1'b0);
    check(hs, 1'b1);
    host.tw_stop();
    check(hs, 1'b0);
  endtask : s_master
  task automatic s_nibble;
    wr(8'hd2, 8'h05, 8'h50, 1'b1);
    wr(8'hd2, 8'h06, 8'h00, 1'b0);
    wr(8'h52, 8'h06, 8'h00, 1'b1);
    check(fw_pins, 1'b1);
    check(sup_io, 1'b1);
  endtask : s_nibble
  task automatic s_four_wire;
    logic [7:0] q;
    host.fw_mode(1'b0, 1'b0, 1'b0);
    host.fw({7'h05, 1'b1, 8'h5f}, q);
    host.fw_mode(1'b1, 1'b1, 1'b1);
    host.fw({7'h05, 1'b1, 8'h00}, q);
    check(q, 8'h5f);
    host.fw({7'h00, 1'b0, 8'h03}, q);
    check(page_sel, 3'h3);
    host.fw({7'h05, 1'b1, 8'h00}, q);
    check(q, 8'h00);
    check(miso_oe, 1'b0);
  endtask : s_four_wire
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    s_reset();
    s_refuse();
    s_modes();
    s_page();
    s_burst();
    s_master();
    s_nibble();
    s_four_wire();
    stop_test();
  end
  // A hung link would otherwise stall the run for good
  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end
endmodule : host_interface_page_config_tb
